// File: rtl/regulator_mode_discharge_regs.sv
// Purpose: Rail six mode register and three discharge selector registers.
// Assumes: Register accesses arrive from the serial port block on ref_clk;
//          rail enables come from the sequencer on ref_clk.
// Notes:   A rising rail enable clears that rail's selector in the same edge,
//          taking priority over a software write in that cycle.
`timescale 1ns/10ps
module regulator_mode_discharge_regs
  import regulator_mode_discharge_pkg::*;
(
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // Register access from the serial port.
  input  wire reg_access_t            access,
  output logic [7:0]                  rdata,
  // Rail enables from the sequencer.
  input  wire logic [NUM_RAILS-1:0]   rail_enable,
  // Controls to the regulators.
  output logic                        rail_six_mode_select,
  output logic [2*NUM_RAILS-1:0]      discharge_sel,
  output discharge_drive_t [NUM_RAILS-1:0] discharge_drive
);

  logic [7:0]           step_down_six_control;
  logic [7:0]           discharge_select_one;
  logic [7:0]           discharge_select_two;
  logic [7:0]           discharge_select_three;
  logic [NUM_RAILS-1:0] enable_prev;
  logic [NUM_RAILS-1:0] enable_rise;
  logic [7:0]           next_step_down_six_control;
  logic [7:0]           next_discharge_select_one;
  logic [7:0]           next_discharge_select_two;
  logic [7:0]           next_discharge_select_three;
  logic [7:0]           clear_mask_one;
  logic [7:0]           clear_mask_two;
  logic [7:0]           clear_mask_three;
  logic                 hit_ctrl;
  logic                 hit_one;
  logic                 hit_two;
  logic                 hit_three;

  // Address decode for writes.
  assign hit_ctrl  = access.wr_en && (access.addr == OFF_STEP_DOWN_SIX_CONTROL);
  assign hit_one   = access.wr_en && (access.addr == OFF_DISCHARGE_SELECT_ONE);
  assign hit_two   = access.wr_en && (access.addr == OFF_DISCHARGE_SELECT_TWO);
  assign hit_three = access.wr_en && (access.addr == OFF_DISCHARGE_SELECT_THREE);

  // A rail becomes enabled on the low-to-high edge of its enable.
  assign enable_rise = rail_enable & ~enable_prev;

  // Bit-pair masks that clear selectors of rails just enabled.
  assign clear_mask_one   = ~{{2{enable_rise[RAIL_FOUR]}},  {2{enable_rise[RAIL_THREE]}},
                              {2{enable_rise[RAIL_TWO]}},   {2{enable_rise[RAIL_ONE]}}};
  assign clear_mask_two   = ~{{2{enable_rise[LINEAR_TWO]}}, {2{enable_rise[SWITCH_A]}},
                              {2{enable_rise[RAIL_SIX]}},   {2{enable_rise[RAIL_FIVE]}}};
  assign clear_mask_three = ~{4'h0, {2{enable_rise[SWITCH_B]}},
                              {2{enable_rise[LINEAR_THREE]}}};

  // Next values: masked write, then on the three selectors the enable clear wins.
  assign next_step_down_six_control = hit_ctrl
    ? (access.wdata & WMASK_STEP_DOWN_SIX_CONTROL)
    : step_down_six_control;
  assign next_discharge_select_one = (hit_one
    ? (access.wdata & WMASK_DISCHARGE_SELECT_ONE)
    : discharge_select_one) & clear_mask_one;
  assign next_discharge_select_two = (hit_two
    ? (access.wdata & WMASK_DISCHARGE_SELECT_TWO)
    : discharge_select_two) & clear_mask_two;
  assign next_discharge_select_three = (hit_three
    ? (access.wdata & WMASK_DISCHARGE_SELECT_THREE)
    : discharge_select_three) & clear_mask_three;

  // Register storage with documented reset values.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      step_down_six_control  <= RST_STEP_DOWN_SIX_CONTROL;
      discharge_select_one   <= RST_DISCHARGE_SELECT_ONE;
      discharge_select_two   <= RST_DISCHARGE_SELECT_TWO;
      discharge_select_three <= RST_DISCHARGE_SELECT_THREE;
      enable_prev            <= '0;
    end
    else
    begin
      step_down_six_control  <= next_step_down_six_control;
      discharge_select_one   <= next_discharge_select_one;
      discharge_select_two   <= next_discharge_select_two;
      discharge_select_three <= next_discharge_select_three;
      enable_prev            <= rail_enable;
    end
  end

  // Read mux; unmapped offsets read zero.
  always_comb
  begin
    unique case (access.addr)
      OFF_STEP_DOWN_SIX_CONTROL:  rdata = step_down_six_control;
      OFF_DISCHARGE_SELECT_ONE:   rdata = discharge_select_one;
      OFF_DISCHARGE_SELECT_TWO:   rdata = discharge_select_two;
      OFF_DISCHARGE_SELECT_THREE: rdata = discharge_select_three;
      default:                    rdata = 8'h00;
    endcase
  end

  // Mode select: 0 automatic, 1 forced PWM.
  assign rail_six_mode_select = step_down_six_control[MODE_SELECT_BIT];

  // Selector vector in rail index order.
  assign discharge_sel = {discharge_select_three[3:0],
                          discharge_select_two[7:6], discharge_select_two[5:4],
                          discharge_select_two[3:2], discharge_select_two[1:0],
                          discharge_select_one};

  // Strength decode per rail.
  genvar g;
  generate
    for (g = 0; g < NUM_RAILS; g++)
    begin : g_rail
      discharge_decode u_decode (
        .sel   (discharge_sel[2*g +: 2]),
        .drive (discharge_drive[g])
      );
    end
  endgenerate

endmodule : regulator_mode_discharge_regs

// File: rtl/regulator_mode_discharge_pkg.sv
// Purpose: Shared constants and types for the regulator mode and discharge register slice.
// Assumes: Byte-wide register access decoded by the serial port block on ref_clk.
// Notes:   The register offsets are the device's own byte offsets.
// How it works
// - Rail six mode bit 1 resets 0; 0 automatic, 1 forced PWM.
// - Rail six control resets 0x3d; bits 7:6 read zero; bits 5:0 writable.
// - Discharge code 00 none, 01 100 ohm, 10 200 ohm, 11 500 ohm.
// - Enabling a rail clears its discharge selector to 00, overriding software.
// - Discharge one resets 0x55; rails four, three, two, one from top pair.
// - Discharge two resets 0x55; linear two, switch A, rails six, five.
// - Discharge three resets 0x05; switch B 3:2, linear three 1:0, 7:6 zero.
package regulator_mode_discharge_pkg;

  // Register offsets.
  localparam logic [7:0] OFF_STEP_DOWN_SIX_CONTROL = 8'h27;
  localparam logic [7:0] OFF_DISCHARGE_SELECT_ONE  = 8'h40;
  localparam logic [7:0] OFF_DISCHARGE_SELECT_TWO  = 8'h41;
  localparam logic [7:0] OFF_DISCHARGE_SELECT_THREE = 8'h42;

  // Reset values.
  localparam logic [7:0] RST_STEP_DOWN_SIX_CONTROL = 8'h3d;
  localparam logic [7:0] RST_DISCHARGE_SELECT_ONE  = 8'h55;
  localparam logic [7:0] RST_DISCHARGE_SELECT_TWO  = 8'h55;
  localparam logic [7:0] RST_DISCHARGE_SELECT_THREE = 8'h05;

  // Writable bit masks; cleared bits are read-only zero.
  localparam logic [7:0] WMASK_STEP_DOWN_SIX_CONTROL = 8'h3f;
  localparam logic [7:0] WMASK_DISCHARGE_SELECT_ONE  = 8'hff;
  localparam logic [7:0] WMASK_DISCHARGE_SELECT_TWO  = 8'hff;
  localparam logic [7:0] WMASK_DISCHARGE_SELECT_THREE = 8'h3f;

  // Field position of the rail six mode select.
  localparam int MODE_SELECT_BIT = 1;

  // Number of rails with a discharge selector, and the cleared code.
  localparam int          NUM_RAILS     = 10;
  localparam logic [1:0]  DISCHARGE_OFF = 2'h0;

  // Rail index order of the enable and discharge vectors.
  localparam int RAIL_ONE     = 0;
  localparam int RAIL_TWO     = 1;
  localparam int RAIL_THREE   = 2;
  localparam int RAIL_FOUR    = 3;
  localparam int RAIL_FIVE    = 4;
  localparam int RAIL_SIX     = 5;
  localparam int SWITCH_A     = 6;
  localparam int LINEAR_TWO   = 7;
  localparam int LINEAR_THREE = 8;
  localparam int SWITCH_B     = 9;

  // Discharge strength codes.
  typedef enum logic [1:0] {
    DIS_NONE    = 2'h0,
    DIS_100_OHM = 2'h1,
    DIS_200_OHM = 2'h2,
    DIS_500_OHM = 2'h3
  } discharge_code_t;

  // One register access from the serial port block.
  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  // Decoded one-hot discharge strength per rail.
  typedef struct packed {
    logic r500;
    logic r200;
    logic r100;
  } discharge_drive_t;

endpackage : regulator_mode_discharge_pkg

// File: rtl/discharge_decode.sv
// Purpose: Turns one two-bit discharge selector into one-hot strength controls.
// Assumes: Selector comes from a flip-flop on the same clock.
// Notes:   Code 00 drives nothing, so the rail floats without discharge.
`timescale 1ns/10ps
module discharge_decode
  import regulator_mode_discharge_pkg::*;
(
  // Selector in.
  input  wire logic [1:0]       sel,
  // Strength controls out.
  output discharge_drive_t      drive
);

  // One strength line per nonzero code.
  assign drive.r100 = (sel == DIS_100_OHM);
  assign drive.r200 = (sel == DIS_200_OHM);
  assign drive.r500 = (sel == DIS_500_OHM);

endmodule : discharge_decode

// File: verif/regulator_mode_discharge_regs_sva.sv
// Purpose: Checker for the mode and discharge register slice.
// Assumes: Sees only the top module ports.
// Notes:   Bound after the module.
`timescale 1ns/10ps
module regulator_mode_discharge_sva
  import regulator_mode_discharge_pkg::*;
(
  // Watched ports.
  input wire logic                   ref_clk,
  input wire logic                   rstn,
  input wire reg_access_t            access,
  input wire logic [7:0]             rdata,
  input wire logic [NUM_RAILS-1:0]   rail_enable,
  input wire logic                   rail_six_mode_select,
  input wire logic [2*NUM_RAILS-1:0] discharge_sel,
  input wire discharge_drive_t [NUM_RAILS-1:0] discharge_drive
);
  // Read data ties to the selector outputs; writes and rises act one edge later.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_MODE: assert property (access.wr_en && access.addr == 8'h27
    |=> rail_six_mode_select == $past(access.wdata[1])) else $error("mode bit not written");
  AST_CTRL_TOP: assert property (access.addr == 8'h27 |-> rdata[7:6] == 2'h0)
    else $error("control top bits not zero");
  AST_ONE: assert property (access.addr == 8'h40 |-> rdata == discharge_sel[7:0])
    else $error("first selector register differs");
  AST_THREE: assert property (access.addr == 8'h42 |-> rdata[7:6] == 2'h0 &&
    rdata[3:0] == discharge_sel[19:16]) else $error("third selector register differs");
  AST_UNMAPPED: assert property (access.addr > 8'h42 |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_DRIVE: assert property (discharge_drive[0] == {discharge_sel[1:0] == 2'h3,
    discharge_sel[1:0] == 2'h2, discharge_sel[1:0] == 2'h1}) else $error("decode wrong");
  AST_CLEAR: assert property (rail_enable[0] && !$past(rail_enable[0])
    |=> discharge_sel[1:0] == 2'h0) else $error("selector not cleared on enable");
  AST_WRITE: assert property (access.wr_en && access.addr == 8'h41 && !(|rail_enable)
    |=> discharge_sel[15:8] == $past(access.wdata)) else $error("write not taken");
  cover property (rail_enable[0] && !$past(rail_enable[0]));
  cover property (access.wr_en && access.addr == 8'h27);
  cover property (discharge_drive[0].r500);
  cover property (access.wr_en && access.addr == 8'h40 && rail_enable[0] && !$past(rail_enable[0]));
endmodule : regulator_mode_discharge_sva

bind regulator_mode_discharge_regs regulator_mode_discharge_sva i_regulator_mode_discharge_sva
  (.ref_clk(ref_clk), .rstn(rstn), .access(access), .rdata(rdata),
  .rail_enable(rail_enable), .rail_six_mode_select(rail_six_mode_select),
  .discharge_sel(discharge_sel), .discharge_drive(discharge_drive));

// File: verif/host_model.sv
// Purpose: Controller side issuing byte register accesses.
// Assumes: Accesses change only just after a rising edge.
// Notes:   Read data is sampled 5 ns after a rising edge, where it has settled.
`timescale 1ns/10ps
module host_model
  import regulator_mode_discharge_pkg::*;
(
  // Clock and read-back.
  input  wire logic       ref_clk,
  input  wire logic [7:0] rdata,
  // Access toward the slice.
  output reg_access_t     access
);
  initial access = '0;
  // Write strobe stands for exactly one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    access <= '{wr_en: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    access.wr_en <= 1'b0;
  endtask : wr
  // Present the offset, then take the data 5 ns after the following edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    access <= '{wr_en: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    #5 d = rdata;
  endtask : rd
endmodule : host_model

// File: verif/regulator_mode_discharge_regs_tb.sv
// Purpose: Self-checking bench for the mode and discharge register slice.
// Assumes: Host model drives accesses; the bench drives rail enables.
// Notes:   A cycle ceiling cuts a hang short.
`timescale 1ns/10ps
module regulator_mode_discharge_regs_tb
  import regulator_mode_discharge_pkg::*;
;
  logic                             ref_clk;
  logic                             rstn;
  logic [NUM_RAILS-1:0]             rail_enable;
  reg_access_t                      access;
  logic [7:0]                       rdata;
  logic [7:0]                       rv;
  logic                             rail_six_mode_select;
  logic [2*NUM_RAILS-1:0]           discharge_sel;
  discharge_drive_t [NUM_RAILS-1:0] discharge_drive;
  int                               err_total = 0;
  int                               n_checks = 0;
  int                               cyc = 0;
  // Design and controller.
  regulator_mode_discharge_regs i_regulator_mode_discharge_regs (.ref_clk(ref_clk),
    .rstn(rstn), .access(access), .rdata(rdata), .rail_enable(rail_enable),
    .rail_six_mode_select(rail_six_mode_select), .discharge_sel(discharge_sel),
    .discharge_drive(discharge_drive));
  host_model i_host_model (.ref_clk(ref_clk), .rdata(rdata), .access(access));
  // Clock of 20 ns.
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Compares one value and counts a mismatch.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Reads one register and compares it.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host_model.rd(a, rv);
    chk(rv, e);
  endtask : rchk
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // Reset values, then read-only bits and unmapped space.
  task automatic t_reset_and_mask();
    rchk(8'h27, 8'h3d);
    rchk(8'h40, 8'h55);
    rchk(8'h41, 8'h55);
    rchk(8'h42, 8'h05);
    chk(discharge_drive[9], 3'b001);
    i_host_model.wr(8'h27, 8'hff);
    i_host_model.wr(8'h42, 8'hff);
    i_host_model.wr(8'h43, 8'hff);
    rchk(8'h27, 8'h3f);
    chk(rail_six_mode_select, 1'b1);
    rchk(8'h42, 8'h3f);
    rchk(8'h43, 8'h00);
    i_host_model.wr(8'h27, 8'h3d);
    rchk(8'h27, 8'h3d);
    chk(rail_six_mode_select, 1'b0);
    $display("reset and mask test ended");
  endtask : t_reset_and_mask
  // Every code on the first four rails, mixed codes on the second register.
  task automatic t_codes();
    i_host_model.wr(8'h40, 8'h1b);
    i_host_model.wr(8'h41, 8'he4);
    rchk(8'h40, 8'h1b);
    chk(discharge_drive[3:0], 12'h054);
    rchk(8'h41, 8'he4);
    chk(discharge_sel[15:8], 8'he4);
    $display("code test ended");
  endtask : t_codes
  // Rising enables clear every selector; later writes are kept.
  task automatic t_enable();
    i_host_model.wr(8'h40, 8'hff);
    i_host_model.wr(8'h41, 8'hff);
    @(posedge ref_clk);
    rail_enable <= '1;
    rchk(8'h40, 8'h00);
    rchk(8'h41, 8'h00);
    rchk(8'h42, 8'h30);
    chk(discharge_drive, 30'h0);
    i_host_model.wr(8'h40, 8'h80);
    rchk(8'h40, 8'h80);
    // Drop rail one, then raise it in the same cycle as a write: the clear wins.
    @(posedge ref_clk);
    rail_enable[RAIL_ONE] <= 1'b0;
    fork
      i_host_model.wr(8'h40, 8'hff);
      begin
        @(posedge ref_clk);
        rail_enable[RAIL_ONE] <= 1'b1;
      end
    join
    rchk(8'h40, 8'hfc);
    $display("enable test ended");
  endtask : t_enable
  // A reset in mid-run restores every register and the mode select.
  task automatic t_reset_again();
    i_host_model.wr(8'h27, 8'h02);
    rchk(8'h27, 8'h02);
    chk(rail_six_mode_select, 1'b1);
    @(posedge ref_clk);
    rstn <= 1'b0;
    rail_enable <= '0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rchk(8'h27, 8'h3d);
    chk(rail_six_mode_select, 1'b0);
    rchk(8'h40, 8'h55);
    rchk(8'h41, 8'h55);
    rchk(8'h42, 8'h05);
    $display("mid-run reset test ended");
  endtask : t_reset_again
  // Hang guard.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 400)
    begin
      err_total++;
      stop_test();
    end
  end
  // Main sequence.
  initial
  begin
    rstn = 1'b0;
    rail_enable = '0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset_and_mask();
    t_codes();
    t_enable();
    t_reset_again();
    stop_test();
  end
endmodule : regulator_mode_discharge_regs_tb
